// ### core/pll_fraction_phase_map.svh
`ifndef PLL_FRACTION_PHASE_MAP_SVH
`define PLL_FRACTION_PHASE_MAP_SVH
`define ADDR_INT_LOW     8'h10
`define ADDR_FRAC_LOW    8'h14
`define ADDR_FRAC_MID    8'h15
`define ADDR_FRAC_HIGH   8'h16
`define ADDR_FRAC_MSB    8'h17
`define ADDR_AUX_HIGH    8'h18
`define ADDR_MOD_LOW     8'h19
`define ADDR_MOD_HIGH    8'h1a
`define ADDR_PH_LOW      8'h1b
`define ADDR_PH_MID      8'h1c
`define ADDR_PH_HIGH     8'h1d
`define RST_ZERO         8'h00
`define RST_MOD_LOW      8'he8
`define RST_MOD_HIGH     8'h03
`define MASK_LOW7        8'h7f
`define BIT_PHASE_EN     6
`define FRAC_BANK_FIRST  3'h0
`define FRAC_BANK_COUNT  7
`define PH_BANK_COUNT    3
`define MASK_ALL         8'hff
`define BYTE_W           8
`define IDX_FRAC_LOW     0
`define IDX_FRAC_MID     1
`define IDX_FRAC_HIGH    2
`define IDX_FRAC_MSB     3
`define IDX_AUX_HIGH     4
`define IDX_MOD_LOW      5
`define IDX_MOD_HIGH     6
`define IDX_PH_LOW       0
`define IDX_PH_MID       1
`define IDX_PH_HIGH      2
`define FRAC_TOP_BIT     0
`define AUX_LOW_LSB      1
`define AUX_HIGH_MSB     6
`define MOD_HIGH_MSB     5
`endif

// ### core/pll_fraction_phase_pkg.sv
package pll_fraction_phase_pkg;
  // words the divider and phase logic consume
  typedef struct packed {
    logic [24:0] primaryFraction;
    logic [13:0] auxiliaryFraction;
    logic [13:0] auxiliaryModulus;
  } divider_words_t;
  typedef struct packed {
    logic        phaseShiftEnable;
    logic [23:0] phaseOffset;
  } phase_ctrl_t;
  // one register bus access
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;
endpackage

// ### core/byte_bank.sv
`include "pll_fraction_phase_map.svh"
module byte_bank
  import pll_fraction_phase_pkg::*;
#(
  parameter int                  DEPTH    = 3,
  parameter logic [DEPTH*8-1:0]  RST_VALS = '0,
  parameter logic [DEPTH*8-1:0]  KEEP     = '1
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // write side
  input  wire logic               wrEn,
  input  wire logic [2:0]         wrIdx,
  input  wire logic [7:0]         wrData,
  // read side, registered
  input  wire logic [2:0]         rdIdx,
  output logic      [7:0]         rdData,
  output logic      [DEPTH*8-1:0] bytes
);
  logic [DEPTH*8-1:0] next_bytes;
  logic [7:0]         next_rdData;

  // masked byte update; masked bits stay at zero
  always_comb begin
    next_bytes = bytes;
    next_rdData = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (wrEn && wrIdx == 3'(i)) begin
        next_bytes[i*8 +: 8] = wrData & KEEP[i*8 +: 8];
      end
      if (rdIdx == 3'(i)) begin
        next_rdData = bytes[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bytes  <= RST_VALS;
      rdData <= `RST_ZERO;
    end else begin
      bytes  <= next_bytes;
      rdData <= next_rdData;
    end
  end
endmodule // byte_bank

// ### core/pll_fraction_phase_regs.sv
`include "pll_fraction_phase_map.svh"
module pll_fraction_phase_regs
  import pll_fraction_phase_pkg::*;
(
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           nrst,
  // register access from the serial interface
  input  wire reg_req_t       req,
  output logic      [7:0]     rdData,
  output logic                rdValid,
  output logic                rdHit,
  // consumers
  output divider_words_t      dividerWords,
  output phase_ctrl_t         phaseCtrl,
  output logic                phaseStep
);
  ////////////////////////////////////////////////////////////////
  // banks: fraction/modulus bytes 0x14..0x1a, phase bytes 0x1b..0x1d
  // reset image of the fraction bank, highest address first
  localparam logic [55:0] FRAC_RST = {
    `RST_MOD_HIGH, // modulus high and phase enable
    `RST_MOD_LOW,  // modulus low
    `RST_ZERO,     // auxiliary fraction high
    `RST_ZERO,     // fraction top bit and auxiliary fraction low
    `RST_ZERO,     // primary fraction high
    `RST_ZERO,     // primary fraction mid
    `RST_ZERO      // primary fraction low
  };
  // bit 7 of 0x18 and 0x1a never stores a one, so it reads zero too
  localparam logic [55:0] FRAC_KEEP = {
    `MASK_LOW7,    // reserved top bit
    `MASK_ALL,
    `MASK_LOW7,    // reserved top bit
    `MASK_ALL,
    `MASK_ALL,
    `MASK_ALL,
    `MASK_ALL
  };

  logic        inFrac;
  logic        inPh;
  logic [2:0]  fracIdx;
  logic [2:0]  phIdx;
  logic [55:0] fracBytes;
  logic [23:0] phBytes;
  logic [7:0]  fracRd;
  logic [7:0]  phRd;
  logic        wrFrac;
  logic        wrPh;
  logic        wrIntLow;

  // address decode shared by both banks
  always_comb begin
    inFrac  = req.addr >= `ADDR_FRAC_LOW && req.addr <= `ADDR_MOD_HIGH;
    inPh    = req.addr >= `ADDR_PH_LOW && req.addr <= `ADDR_PH_HIGH;
    fracIdx = 3'(req.addr - `ADDR_FRAC_LOW);
    phIdx   = 3'(req.addr - `ADDR_PH_LOW);
    // write strobes per target; unmapped writes go nowhere
    wrFrac   = req.wrEn && inFrac;
    wrPh     = req.wrEn && inPh;
    wrIntLow = req.wrEn && req.addr == `ADDR_INT_LOW;
  end

  byte_bank #(
    .DEPTH    (`FRAC_BANK_COUNT),
    .RST_VALS (FRAC_RST),
    .KEEP     (FRAC_KEEP)
  ) fracBank (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wrEn    (wrFrac),
    .wrIdx   (fracIdx),
    .wrData  (req.data),
    .rdIdx   (fracIdx),
    .rdData  (fracRd),
    .bytes   (fracBytes)
  );

  byte_bank #(
    .DEPTH    (`PH_BANK_COUNT),
    .RST_VALS (24'h000000),
    .KEEP     (24'hffffff)
  ) phBank (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wrEn    (wrPh),
    .wrIdx   (phIdx),
    .wrData  (req.data),
    .rdIdx   (phIdx),
    .rdData  (phRd),
    .bytes   (phBytes)
  );

  ////////////////////////////////////////////////////////////////
  // byte views of the banks, named after the registers they mirror
  logic [7:0] fracLowByte;
  logic [7:0] fracMidByte;
  logic [7:0] fracHighByte;
  logic [7:0] fracTopAuxByte;
  logic [7:0] auxHighByte;
  logic [7:0] modLowByte;
  logic [7:0] modHighByte;
  logic [7:0] phLowByte;
  logic [7:0] phMidByte;
  logic [7:0] phHighByte;

  // fixed slices only; no logic, just names for the assembly below
  always_comb begin
    fracLowByte    = fracBytes[`IDX_FRAC_LOW*`BYTE_W +: `BYTE_W];
    fracMidByte    = fracBytes[`IDX_FRAC_MID*`BYTE_W +: `BYTE_W];
    fracHighByte   = fracBytes[`IDX_FRAC_HIGH*`BYTE_W +: `BYTE_W];
    fracTopAuxByte = fracBytes[`IDX_FRAC_MSB*`BYTE_W +: `BYTE_W];
    auxHighByte    = fracBytes[`IDX_AUX_HIGH*`BYTE_W +: `BYTE_W];
    modLowByte     = fracBytes[`IDX_MOD_LOW*`BYTE_W +: `BYTE_W];
    modHighByte    = fracBytes[`IDX_MOD_HIGH*`BYTE_W +: `BYTE_W];
    phLowByte      = phBytes[`IDX_PH_LOW*`BYTE_W +: `BYTE_W];
    phMidByte      = phBytes[`IDX_PH_MID*`BYTE_W +: `BYTE_W];
    phHighByte     = phBytes[`IDX_PH_HIGH*`BYTE_W +: `BYTE_W];
  end

  ////////////////////////////////////////////////////////////////
  // readback timing: bank read data lands one cycle after the request
  logic       rdPend;
  logic       rdSelPh;
  logic       rdSelHit;
  logic       next_rdPend;
  logic       next_rdSelPh;
  logic       next_rdSelHit;
  logic [7:0] next_rdData;
  logic       next_rdValid;
  logic       next_rdHit;

  always_comb begin
    next_rdPend   = req.rdEn;
    next_rdSelPh  = inPh;
    next_rdSelHit = inFrac || inPh;
    next_rdValid  = rdPend;
    next_rdHit    = rdPend && rdSelHit;
    next_rdData   = rdData;
    // data only moves on an answer, so it stands until the next one
    if (rdPend) begin
      if (!rdSelHit) begin
        next_rdData = `RST_ZERO; // unmapped addresses read zero
      end else if (rdSelPh) begin
        next_rdData = phRd;
      end else begin
        next_rdData = fracRd;
      end
    end
  end

  // answer registers; reset leaves a quiet read port
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdPend   <= 1'b0;
      rdSelPh  <= 1'b0;
      rdSelHit <= 1'b0;
      rdData   <= `RST_ZERO;
      rdValid  <= 1'b0;
      rdHit    <= 1'b0;
    end else begin
      rdPend   <= next_rdPend;
      rdSelPh  <= next_rdSelPh;
      rdSelHit <= next_rdSelHit;
      rdData   <= next_rdData;
      rdValid  <= next_rdValid;
      rdHit    <= next_rdHit;
    end
  end

  ////////////////////////////////////////////////////////////////
  // double buffer: shadow bytes reach the divider on integer low write
  divider_words_t staged;
  divider_words_t next_dividerWords;
  logic           loadPend;
  logic           next_loadPend;
  // modulus reset image, the two bytes that feed it
  localparam logic [15:0] MOD_RST = {`RST_MOD_HIGH, `RST_MOD_LOW};

  // bank bytes are stored one cycle after the write, so load one later
  always_comb begin
    staged.primaryFraction   = {fracTopAuxByte[`FRAC_TOP_BIT], fracHighByte, fracMidByte,
                                fracLowByte};
    staged.auxiliaryFraction = {auxHighByte[`AUX_HIGH_MSB:0],
                                fracTopAuxByte[`BYTE_W-1:`AUX_LOW_LSB]};
    staged.auxiliaryModulus  = {modHighByte[`MOD_HIGH_MSB:0], modLowByte};
    next_loadPend     = wrIntLow;
    next_dividerWords = loadPend ? staged : dividerWords;
  end

  // divider words reset to the bank's own reset image
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loadPend     <= 1'b0;
      dividerWords <= {25'h0, 14'h0, MOD_RST[13:0]};
    end else begin
      loadPend     <= next_loadPend;
      dividerWords <= next_dividerWords;
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase control: offset counts in units of 360 / 2^24 degrees
  phase_ctrl_t next_phaseCtrl;
  logic        next_phaseStep;

  // a one-cycle step pulse when the enable rises asks the loop to advance once
  always_comb begin
    next_phaseCtrl.phaseShiftEnable = modHighByte[`BIT_PHASE_EN];
    // offset passes even while disabled; host keeps it zero then
    next_phaseCtrl.phaseOffset      = {phHighByte, phMidByte, phLowByte};
    next_phaseStep = next_phaseCtrl.phaseShiftEnable && !phaseCtrl.phaseShiftEnable;
  end

  // enable and step registered together so they rise in one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phaseCtrl <= '0;
      phaseStep <= 1'b0;
    end else begin
      phaseCtrl <= next_phaseCtrl;
      phaseStep <= next_phaseStep;
    end
  end
endmodule // pll_fraction_phase_regs

// ### tb/pll_fraction_phase_regs_asserts.sv
module pll_fraction_phase_regs_chk
  import pll_fraction_phase_pkg::*;
(
  // clock and reset
  input wire logic           ref_clk,
  input wire logic           nrst,
  // watched ports
  input wire reg_req_t       req,
  input wire logic [7:0]     rdData,
  input wire logic           rdValid,
  input wire logic           rdHit,
  input wire divider_words_t dividerWords,
  input wire phase_ctrl_t    phaseCtrl,
  input wire logic           phaseStep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // read answer timing and decode
  AST_RD_LAT: assert property (req.rdEn |-> ##2 rdValid)
    else $error("read answer missing");
  AST_RD_CAUSE: assert property (rdValid |-> $past(req.rdEn, 2))
    else $error("read answer without request");
  AST_HIT: assert property (
    rdValid && $past(req.addr, 2) inside {[8'h14:8'h1d]} |-> rdHit)
    else $error("mapped byte not hit");
  AST_MISS: assert property (
    rdValid && $past(req.addr, 2) > 8'h1d |-> !rdHit && rdData == 8'h00)
    else $error("unmapped byte answered");
  // reserved top bits never read back set
  AST_RSV: assert property (
    rdValid && $past(req.addr, 2) inside {8'h18, 8'h1a} |-> !rdData[7])
    else $error("reserved bit read as one");
  // divider words move only on the integer low byte trigger
  AST_DIV_LOAD: assert property (
    $changed(dividerWords) |-> $past(req.wrEn, 2) && $past(req.addr, 2) == 8'h10)
    else $error("divider words moved without trigger");
  AST_PH_OFS: assert property (
    $changed(phaseCtrl.phaseOffset) |->
      $past(req.wrEn, 2) && $past(req.addr, 2) inside {[8'h1b:8'h1d]})
    else $error("phase offset moved without write");
  AST_PH_EN: assert property (
    $rose(phaseCtrl.phaseShiftEnable) |->
      $past(req.wrEn, 2) && $past(req.addr, 2) == 8'h1a && $past(req.data, 2) & 8'h40)
    else $error("phase enable rose without write");
  AST_STEP: assert property (phaseStep |=> !phaseStep)
    else $error("phase step wider than one cycle");
  // main scenarios reached
  CV_HIT: cover property (rdValid && rdHit);
  CV_STEP: cover property (phaseStep);
  CV_LOAD: cover property ($changed(dividerWords));
endmodule // pll_fraction_phase_regs_chk

bind pll_fraction_phase_regs pll_fraction_phase_regs_chk chk (.ref_clk, .nrst, .req, .rdData,
  .rdValid, .rdHit, .dividerWords, .phaseCtrl, .phaseStep);

// ### tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pll_fraction_phase_pkg::*;
  logic           ref_clk;
  logic           nrst;
  reg_req_t       req;
  logic [7:0]     rdData;
  logic           rdValid;
  logic           rdHit;
  divider_words_t dividerWords;
  phase_ctrl_t    phaseCtrl;
  logic           phaseStep;
  int             err_count = 0;
  int             tests_run = 0;
  int             steps = 0;
  logic [7:0]     pat [7] = '{8'h11, 8'h22, 8'h33, 8'hff, 8'hff, 8'h55, 8'hff};
  pll_fraction_phase_regs dut (.ref_clk, .nrst, .req, .rdData, .rdValid, .rdHit,
    .dividerWords, .phaseCtrl, .phaseStep);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes, driven off the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wrEn = 1'b1;
    req.addr = a;
    req.data = d;
    @(negedge ref_clk);
    req.wrEn = 1'b0;
    @(negedge ref_clk); // an edge passes before the next strobe may rise
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    req.rdEn = 1'b1;
    req.addr = a;
    @(negedge ref_clk);
    req.rdEn = 1'b0;
    @(negedge ref_clk); // rdValid and rdHit stand for one cycle only; rdData holds until the next answer
    chk("rdValid", 32'h1, {31'h0, rdValid});
    chk("rdHit", {31'h0, hit}, {31'h0, rdHit});
    chk("rdData", {24'h0, exp}, {24'h0, rdData});
  endtask
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // clock, step counter and watchdog; run needs about 80 cycles
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (phaseStep === 1'b1) steps++;
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    req = '0;
    nrst = 1'b0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    for (int a = 'h14; a <= 'h1d; a++) begin
      rd(8'(a), a == 'h19 ? 8'he8 : a == 'h1a ? 8'h03 : 8'h00, 1'b1);
    end
    chk("mod", 32'h3e8, {18'h0, dividerWords.auxiliaryModulus});
    for (int i = 0; i < 7; i++) wr(8'h14 + 8'(i), pat[i]);
    repeat (2) @(negedge ref_clk);
    chk("frac", 32'h0, {7'h0, dividerWords.primaryFraction});
    chk("enable", 32'h1, {31'h0, phaseCtrl.phaseShiftEnable});
    wr(8'h10, 8'h32);
    repeat (2) @(negedge ref_clk);
    chk("frac", 32'h1332211, {7'h0, dividerWords.primaryFraction});
    chk("aux", 32'h3fff, {18'h0, dividerWords.auxiliaryFraction});
    chk("mod", 32'h3f55, {18'h0, dividerWords.auxiliaryModulus});
    rd(8'h18, 8'h7f, 1'b1);
    rd(8'h1a, 8'h7f, 1'b1);
    wr(8'h1b, 8'h01);
    wr(8'h1c, 8'h80);
    wr(8'h1d, 8'hc3);
    repeat (2) @(negedge ref_clk);
    chk("offset", 32'hc38001, {8'h0, phaseCtrl.phaseOffset});
    rd(8'h1d, 8'hc3, 1'b1);
    wr(8'h1a, 8'h3f);
    for (int i = 0; i < 3; i++) wr(8'h1b + 8'(i), 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("enable", 32'h0, {31'h0, phaseCtrl.phaseShiftEnable});
    chk("steps", 32'h1, 32'(steps));
    chk("offset", 32'h0, {8'h0, phaseCtrl.phaseOffset});
    // write then read at once, trigger not repeated so the word must hold
    wr(8'h14, 8'h5a);
    rd(8'h14, 8'h5a, 1'b1);
    chk("frac", 32'h1332211, {7'h0, dividerWords.primaryFraction});
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00, 1'b0);
    stop_test();
  end
endmodule // testbench
